// file: src/eess_consts.svh
`ifndef EESS_CONSTS_SVH
`define EESS_CONSTS_SVH

// register indices; byte address is four times the index
`define EESS_IDX_L1_CNT    14'h0E37
`define EESS_IDX_L1_START  14'h0E38
`define EESS_IDX_L2G_CNT   14'h0E3A
`define EESS_IDX_L2G_START 14'h0E3B
`define EESS_IDX_L2A_CNT   14'h0E3D
`define EESS_IDX_L2A_START 14'h0E3E
`define EESS_IDX_CTRL      14'h0E00
`define EESS_IDX_STAT      14'h0E01

// default sequence bytes
`define EESS_RST_L1_CNT    8'h33
`define EESS_RST_L1_START  16'h0540
`define EESS_RST_L2G_CNT   8'h1E
`define EESS_RST_L2G_START 16'h0600
`define EESS_RST_L2A_CNT   8'h0E
`define EESS_RST_L2A_START 16'h0630

// sequence layout
`define EESS_NUM_ENT       2'd3
`define EESS_LAST_ENT      2'd2
`define EESS_HDR_LAST      2'd2
`define EESS_SEQ_BYTES     9
`define EESS_HDR_BYTES     16'h0003

// control and status bits
`define EESS_CTRL_GO       0
`define EESS_CTRL_CLR      1

`define EESS_RESP_OKAY     2'h0
`define EESS_RESP_SLVERR   2'h2

`endif

// file: src/eess_pkg.sv
package eess_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR_RD,
    ST_HDR_LD,
    ST_HDR_WR,
    ST_MAP_RD,
    ST_PAY_WR
  } eess_state_t;

  typedef enum logic [3:0] {
    REG_L1_CNT,
    REG_L1_START,
    REG_L2G_CNT,
    REG_L2G_START,
    REG_L2A_CNT,
    REG_L2A_START,
    REG_CTRL,
    REG_STAT,
    REG_NONE
  } eess_reg_t;

endpackage

// file: src/eess_seq_mem.sv
`include "eess_consts.svh"

module eess_seq_mem #(
  parameter int NB = `EESS_SEQ_BYTES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        we,
  input  wire logic [3:0]  widx,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  wbe,
  input  wire logic        a_en,
  input  wire logic [3:0]  a_idx,
  output logic      [15:0] a_rdata,
  input  wire logic        b_en,
  input  wire logic [3:0]  b_idx,
  output logic      [15:0] b_rdata
);
  import eess_pkg::*;

  localparam logic [7:0] DEF [NB] = '{
    `EESS_RST_L1_CNT,
    8'(`EESS_RST_L1_START >> 8),
    8'(`EESS_RST_L1_START),
    `EESS_RST_L2G_CNT,
    8'(`EESS_RST_L2G_START >> 8),
    8'(`EESS_RST_L2G_START),
    `EESS_RST_L2A_CNT,
    8'(`EESS_RST_L2A_START >> 8),
    8'(`EESS_RST_L2A_START)};

  logic [7:0] mem_q [NB];
  logic [3:0] wnxt;

  assign wnxt = widx + 4'h1;

  // out-of-range index reads zero rather than wrapping
  function automatic logic [7:0] byte_at(input logic [3:0] idx);
    return (int'(idx) < NB) ? mem_q[idx] : 8'h00;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NB; i++) begin
        mem_q[i] <= DEF[i]; // R6 R7 R8
      end
    end else if (we) begin
      if (wbe[1] && int'(widx) < NB) begin
        mem_q[widx] <= wdata[15:8];
      end
      if (wbe[0] && int'(wnxt) < NB) begin
        mem_q[wnxt] <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_rdata <= 16'h0000;
      b_rdata <= 16'h0000;
    end else begin
      if (a_en) begin
        a_rdata <= {byte_at(a_idx), byte_at(a_idx + 4'h1)};
      end
      if (b_en) begin
        b_rdata <= {byte_at(b_idx), byte_at(b_idx + 4'h1)};
      end
    end
  end

  a_reset_defaults: assert property (@(posedge aclk) // R6 R7 R8
    aresetn && $past(!aresetn) |-> mem_q[0] == 8'h33 && {mem_q[1], mem_q[2]} == 16'h0540
      && mem_q[3] == 8'h1E && {mem_q[4], mem_q[5]} == 16'h0600
      && mem_q[6] == 8'h0E && {mem_q[7], mem_q[8]} == 16'h0630)
    else $error("sequence bytes not at defaults after reset");

endmodule // eess_seq_mem

// file: src/eess_store_slice.sv
// Functional notes
// R1: instruction byte n moves n plus one register-map bytes to the EEPROM.
// R2: instruction byte itself is written to the EEPROM, pointer advances one.
// R3: the two following sequence bytes are the register-map start address.
// R4: both start-address bytes are stored, pointer advances two, before payload.
// R5: payload copies from consecutive map addresses, pointer advances by count plus one.
// R6: loop-one divider entry defaults to 0x33 and start 0x0540.
// R7: loop-two general entry defaults to 0x1E and start 0x0600.
// R8: loop-two analog entry defaults to 0x0E and start 0x0630.
// R9: transfer length always comes from instruction byte plus one.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`include "eess_consts.svh"

module eess_store_slice #(
  parameter int PTR_W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [15:0]      s_awaddr,
  input  wire logic             s_awvalid,
  output logic                  s_awready,
  input  wire logic [31:0]      s_wdata,
  input  wire logic [3:0]       s_wstrb,
  input  wire logic             s_wvalid,
  output logic                  s_wready,
  output logic      [1:0]       s_bresp,
  output logic                  s_bvalid,
  input  wire logic             s_bready,
  input  wire logic [15:0]      s_araddr,
  input  wire logic             s_arvalid,
  output logic                  s_arready,
  output logic      [31:0]      s_rdata,
  output logic      [1:0]       s_rresp,
  output logic                  s_rvalid,
  input  wire logic             s_rready,
  input  wire logic             seq_start,
  input  wire logic [PTR_W-1:0] seq_ptr_base,
  output logic                  seq_busy,
  output logic                  seq_done,
  output logic      [PTR_W-1:0] ee_ptr,
  output logic                  ee_wvalid,
  input  wire logic             ee_wready,
  output logic      [PTR_W-1:0] ee_waddr,
  output logic      [7:0]       ee_wdata,
  output logic                  map_req,
  output logic      [15:0]      map_addr,
  input  wire logic             map_rvalid,
  input  wire logic [7:0]       map_rdata
);
  import eess_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic eess_reg_t reg_decode(input logic [15:0] addr);
    eess_reg_t r;
    r = REG_NONE;
    if (addr[1:0] == 2'b00) begin
      case (addr[15:2])
        `EESS_IDX_L1_CNT:    r = REG_L1_CNT;
        `EESS_IDX_L1_START:  r = REG_L1_START;
        `EESS_IDX_L2G_CNT:   r = REG_L2G_CNT;
        `EESS_IDX_L2G_START: r = REG_L2G_START;
        `EESS_IDX_L2A_CNT:   r = REG_L2A_CNT;
        `EESS_IDX_L2A_START: r = REG_L2A_START;
        `EESS_IDX_CTRL:      r = REG_CTRL;
        `EESS_IDX_STAT:      r = REG_STAT;
        default:             r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // count regs map to entry*3, start regs to entry*3+1 (high byte first)
  function automatic logic [3:0] reg_mem_idx(input eess_reg_t r);
    logic [3:0] c;
    c = 4'(r);
    return 4'(int'(c >> 1) * 3 + int'(c[0]));
  endfunction

  // ---------------- AXI4-Lite write path ----------------
  logic        aw_full_q;
  logic        w_full_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdat_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  eess_reg_t   wr_reg;
  logic        sw_go;
  logic        sw_clr;
  logic        mem_we;
  logic [15:0] mem_wdata;
  logic [1:0]  mem_wbe;

  assign s_awready = !aw_full_q && !bvalid_q;
  assign s_wready  = !w_full_q && !bvalid_q;
  assign wr_fire   = aw_full_q && w_full_q;
  assign wr_reg    = reg_decode(awaddr_q);
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= 16'h0000;
    end else if (s_awvalid && s_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdat_q   <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_full_q <= 1'b1;
      wdat_q   <= s_wdata;
      wstrb_q  <= s_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `EESS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_reg == REG_NONE) ? `EESS_RESP_SLVERR : `EESS_RESP_OKAY;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // byte lanes: count in lane 0, start low in lane 0 and high in lane 1
  assign mem_we    = wr_fire && (wr_reg < REG_CTRL);
  assign mem_wdata = wr_reg[0] ? wdat_q[15:0] : {wdat_q[7:0], 8'h00};
  assign mem_wbe   = wr_reg[0] ? wstrb_q[1:0] : {wstrb_q[0], 1'b0};
  assign sw_go     = wr_fire && wr_reg == REG_CTRL && wstrb_q[0] && wdat_q[`EESS_CTRL_GO];
  assign sw_clr    = wr_fire && wr_reg == REG_CTRL && wstrb_q[0] && wdat_q[`EESS_CTRL_CLR];

  // ---------------- AXI4-Lite read path ----------------
  logic        rpend_q;
  logic        rvalid_q;
  eess_reg_t   rreg_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        ar_fire;
  eess_reg_t   rd_reg;
  logic [15:0] a_rdata;
  logic [31:0] rd_word;
  logic        done_q;

  assign s_arready = !rpend_q && !rvalid_q;
  assign ar_fire   = s_arvalid && s_arready;
  assign rd_reg    = reg_decode(s_araddr);
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rreg_q == REG_STAT) begin
      rd_word = {16'(ee_ptr), 14'h0000, done_q, seq_busy};
    end else if (rreg_q < REG_CTRL) begin
      rd_word = rreg_q[0] ? {16'h0000, a_rdata} : {24'h000000, a_rdata[15:8]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpend_q  <= 1'b0;
      rvalid_q <= 1'b0;
      rreg_q   <= REG_NONE;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `EESS_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rpend_q <= 1'b1;
        rreg_q  <= rd_reg;
      end
      if (rpend_q) begin
        rpend_q  <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= (rreg_q == REG_NONE) ? `EESS_RESP_SLVERR : `EESS_RESP_OKAY;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- storage engine ----------------
  eess_state_t      st_q;
  logic [1:0]       ent_q;
  logic [1:0]       fld_q;
  logic [7:0]       len_q;
  logic [15:0]      start_q;
  logic [7:0]       off_q;
  logic [15:0]      map_addr_q;
  logic [7:0]       wbyte_q;
  logic [PTR_W-1:0] ptr_q;
  logic             done_pulse_q;
  logic             go;
  logic             ee_take;
  logic             pay_last;
  logic [15:0]      b_rdata;

  assign go       = (seq_start || sw_go) && st_q == ST_IDLE;
  assign ee_take  = ee_wvalid && ee_wready;
  assign pay_last = st_q == ST_PAY_WR && ee_wready && off_q == len_q; // R1 R9
  assign seq_busy = st_q != ST_IDLE;
  assign seq_done = done_pulse_q;
  assign ee_wvalid = st_q == ST_HDR_WR || st_q == ST_PAY_WR;
  assign ee_waddr = ptr_q;
  assign ee_wdata = wbyte_q;
  assign ee_ptr   = ptr_q;
  assign map_req  = st_q == ST_MAP_RD;
  assign map_addr = map_addr_q;

  eess_seq_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we),
    .widx    (reg_mem_idx(wr_reg)),
    .wdata   (mem_wdata),
    .wbe     (mem_wbe),
    .a_en    (ar_fire),
    .a_idx   (reg_mem_idx(rd_reg)),
    .a_rdata (a_rdata),
    .b_en    (st_q == ST_HDR_RD),
    .b_idx   (4'(int'(ent_q) * 3 + int'(fld_q))),
    .b_rdata (b_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE:   if (go) st_q <= ST_HDR_RD;
        ST_HDR_RD: st_q <= ST_HDR_LD;
        ST_HDR_LD: st_q <= ST_HDR_WR;
        ST_HDR_WR: begin
          if (ee_wready) begin
            st_q <= (fld_q == `EESS_HDR_LAST) ? ST_MAP_RD : ST_HDR_RD; // R4
          end
        end
        ST_MAP_RD: if (map_rvalid) st_q <= ST_PAY_WR;
        ST_PAY_WR: begin
          if (pay_last) begin
            st_q <= (ent_q == `EESS_LAST_ENT) ? ST_IDLE : ST_HDR_RD;
          end else if (ee_wready) begin
            st_q <= ST_MAP_RD; // R5
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ent_q <= 2'd0;
      fld_q <= 2'd0;
    end else if (go) begin
      ent_q <= 2'd0;
      fld_q <= 2'd0;
    end else if (st_q == ST_HDR_WR && ee_wready) begin
      fld_q <= (fld_q == `EESS_HDR_LAST) ? 2'd0 : fld_q + 2'd1;
    end else if (pay_last) begin
      ent_q <= ent_q + 2'd1;
    end
  end

  // header byte goes out exactly as held; payload byte as read from the map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q   <= 8'h00;
      start_q <= 16'h0000;
      wbyte_q <= 8'h00;
    end else if (st_q == ST_HDR_LD) begin
      wbyte_q <= b_rdata[15:8]; // R2
      unique case (fld_q)
        2'd0:    len_q          <= b_rdata[15:8]; // R9
        2'd1:    start_q[15:8]  <= b_rdata[15:8]; // R3
        default: start_q[7:0]   <= b_rdata[15:8]; // R3
      endcase
    end else if (st_q == ST_MAP_RD && map_rvalid) begin
      wbyte_q <= map_rdata; // R5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_q      <= 8'h00;
      map_addr_q <= 16'h0000;
    end else if (st_q == ST_HDR_WR && ee_wready && fld_q == `EESS_HDR_LAST) begin
      off_q      <= 8'h00;
      map_addr_q <= start_q; // R3
    end else if (st_q == ST_PAY_WR && ee_wready) begin
      off_q      <= off_q + 8'h01;
      map_addr_q <= map_addr_q + 16'h0001; // R5
    end
  end

  // one pointer step per byte taken: +1 instruction, +2 address, +n+1 payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= '0;
    end else if (go) begin
      ptr_q <= seq_ptr_base;
    end else if (ee_take) begin
      ptr_q <= ptr_q + 1'b1; // R2 R4 R5
    end
  end

  // completion flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_pulse_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      done_pulse_q <= pay_last && ent_q == `EESS_LAST_ENT;
      if (pay_last && ent_q == `EESS_LAST_ENT) begin
        done_q <= 1'b1;
      end else if (sw_clr || go) begin
        done_q <= 1'b0;
      end
    end
  end

  // ---------------- checks ----------------
  logic [PTR_W-1:0] ent_ptr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ent_ptr_q <= '0;
    end else if (st_q == ST_HDR_LD && fld_q == 2'd0) begin
      ent_ptr_q <= ptr_q;
    end
  end

  sequence s_hdr_done;
    st_q == ST_HDR_WR && ee_wready && fld_q == `EESS_HDR_LAST;
  endsequence

  a_ptr_one_step: assert property (ee_take |=> ptr_q == $past(ptr_q) + 1'b1) // R2
    else $error("pointer did not advance by one per stored byte");
  a_instr_first: assert property ((st_q == ST_HDR_WR && fld_q == 2'd0) |-> ee_wdata == len_q) // R2
    else $error("instruction byte not stored first");
  a_addr_before_pay: assert property ($rose(map_req) && off_q == 8'h00 // R4
    |-> $past(st_q) == ST_HDR_WR && $past(fld_q) == `EESS_HDR_LAST)
    else $error("payload began before both address bytes stored");
  a_pay_start_addr: assert property (s_hdr_done |=> map_addr == start_q && off_q == 8'h00) // R3
    else $error("payload does not start at stored address");
  a_map_addr_walk: assert property (map_req |-> map_addr == 16'(start_q + 16'(off_q))) // R5
    else $error("payload address not consecutive");
  a_entry_length: assert property (pay_last // R1
    |-> PTR_W'(ptr_q + 1'b1 - ent_ptr_q) == PTR_W'(16'(len_q) + `EESS_HDR_BYTES + 16'h0001))
    else $error("entry stored wrong byte count");
  a_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before taken");
  a_read_latency: assert property (ar_fire |-> ##2 s_rvalid)
    else $error("read data not returned two cycles after address");
  a_done_pulse: assert property (seq_done |-> !seq_busy ##1 !seq_done) // R1
    else $error("completion not a single pulse at idle");

endmodule // eess_store_slice

// file: verif/eess_far_model.sv
// far side: serial eeprom sink plus register-map byte source
module eess_far_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ee_wvalid,
  output logic             ee_wready,
  input  wire logic [15:0] ee_waddr,
  input  wire logic [7:0]  ee_wdata,
  input  wire logic        map_req,
  input  wire logic [15:0] map_addr,
  output logic             map_rvalid,
  output logic      [7:0]  map_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ee_mem_q [int];

  // random stalls on both sides, so slow and prompt answers both occur
  always @(posedge aclk) begin
    if (!aresetn) begin
      ee_wready  <= 1'b0;
      map_rvalid <= 1'b0;
      map_rdata  <= 8'h00;
    end else begin
      ee_wready  <= ($urandom % 4) != 0;
      if (ee_wvalid && ee_wready)
        ee_mem_q[ee_waddr] = ee_wdata;
      map_rvalid <= 1'b0;
      // data line shows noise outside its valid cycle
      map_rdata  <= 8'($urandom);
      if (map_req && !map_rvalid && ($urandom % 3) == 0) begin
        map_rvalid <= 1'b1;
        map_rdata  <= map_addr[7:0] ^ map_addr[15:8] ^ 8'h5A;
      end
    end
  end
endmodule // eess_far_model

// file: verif/tb.sv
`include "eess_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0;
  logic [15:0] s_awaddr = 0, s_araddr = 0, seq_ptr_base = 0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = 0;
  logic [3:0]  s_wstrb = 0;
  logic        seq_start = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic        seq_busy, seq_done, ee_wvalid, ee_wready, map_req, map_rvalid;
  logic [15:0] ee_ptr, ee_waddr, map_addr, end_ptr;
  logic [7:0]  ee_wdata, map_rdata;
  logic [23:0] exp_ee_q [$];
  logic [33:0] exp_rd_q [$];
  logic [1:0]  exp_b_q [$];
  logic [7:0]  cnt_m [3];
  logic [15:0] st_m [3];
  logic [13:0] cidx [3] = '{`EESS_IDX_L1_CNT, `EESS_IDX_L2G_CNT, `EESS_IDX_L2A_CNT};
  int          n_errors = 0, n_tests = 0;

  initial forever #5 aclk = ~aclk;

  eess_store_slice #(.PTR_W(16)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .seq_start(seq_start), .seq_ptr_base(seq_ptr_base), .seq_busy(seq_busy),
    .seq_done(seq_done), .ee_ptr(ee_ptr), .ee_wvalid(ee_wvalid), .ee_wready(ee_wready),
    .ee_waddr(ee_waddr), .ee_wdata(ee_wdata), .map_req(map_req), .map_addr(map_addr),
    .map_rvalid(map_rvalid), .map_rdata(map_rdata));

  eess_far_model far (.aclk(aclk), .aresetn(aresetn), .ee_wvalid(ee_wvalid),
    .ee_wready(ee_wready), .ee_waddr(ee_waddr), .ee_wdata(ee_wdata), .map_req(map_req),
    .map_addr(map_addr), .map_rvalid(map_rvalid), .map_rdata(map_rdata));

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tmo(input string w);
    n_errors++;
    $display("MISMATCH timeout %s exp=1 got=0", w);
    test_done();
  endtask

  // result watcher: oldest note against each result that appears
  always @(posedge aclk) begin : watch
    logic [23:0] ee_e;
    logic [33:0] rd_e;
    logic [1:0]  b_e;
    // pop once into a local: the macro names its expected value twice
    if (ee_wvalid && ee_wready) begin
      if (exp_ee_q.size() == 0) `CHK("ee_extra", 1'b0, 1'b1)
      else begin
        ee_e = exp_ee_q.pop_front();
        `CHK("ee_byte", ee_e, {ee_waddr, ee_wdata})
      end
    end
    if (s_rvalid && s_rready) begin
      if (exp_rd_q.size() == 0) `CHK("rd_extra", 1'b0, 1'b1)
      else begin
        rd_e = exp_rd_q.pop_front();
        `CHK("rd", rd_e, {s_rresp, s_rdata})
      end
    end
    if (s_bvalid && s_bready) begin
      if (exp_b_q.size() == 0) `CHK("b_extra", 1'b0, 1'b1)
      else begin
        b_e = exp_b_q.pop_front();
        `CHK("bresp", b_e, s_bresp)
      end
    end
  end

  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    bit done = 0;
    exp_b_q.push_back(er);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= st;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        s_bready <= 1'b0;
        done = 1;
      end
    end
    // an idle edge, so a following call never reassigns bready in this step
    if (!done) tmo("write");
    else @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [15:0] a, input logic [33:0] e);
    bit done = 0;
    exp_rd_q.push_back(e);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        s_rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo("read");
    else @(posedge aclk);
  endtask

  task automatic chk_regs();
    for (int k = 0; k < 3; k++) begin
      axi_rd(ba(cidx[k]), {2'b00, 24'h0, cnt_m[k]});
      axi_rd(ba(cidx[k] + 14'h1), {2'b00, 16'h0, st_m[k]});
    end
  endtask

  // header byte, start high, start low, then count+1 map bytes per entry
  task automatic expect_run(input logic [15:0] base);
    logic [15:0] p;
    logic [15:0] a;
    p = base;
    for (int k = 0; k < 3; k++) begin
      exp_ee_q.push_back({p, cnt_m[k]});
      exp_ee_q.push_back({p + 16'h1, st_m[k][15:8]});
      exp_ee_q.push_back({p + 16'h2, st_m[k][7:0]});
      p = p + `EESS_HDR_BYTES;
      for (int i = 0; i <= int'(cnt_m[k]); i++) begin
        a = st_m[k] + 16'(i);
        exp_ee_q.push_back({p, a[7:0] ^ a[15:8] ^ 8'h5A});
        p++;
      end
    end
    end_ptr = p;
  endtask

  task automatic wait_done();
    int n;
    for (n = 0; n < 20000 && seq_done !== 1'b1; n++) @(posedge aclk);
    if (n == 20000) tmo("done");
    `CHK("ptr", end_ptr, ee_ptr)
    `CHK("left", 0, exp_ee_q.size())
    @(posedge aclk);
    `CHK("busy", 1'b0, seq_busy)
    axi_rd(ba(`EESS_IDX_STAT), {2'b00, end_ptr, 16'h0002});
    axi_wr(ba(`EESS_IDX_CTRL), 32'h2, 4'hF, `EESS_RESP_OKAY);
    axi_rd(ba(`EESS_IDX_STAT), {2'b00, end_ptr, 16'h0000});
  endtask

  initial begin
    logic [15:0] base;
    void'($urandom(32));
    cnt_m = '{8'h33, 8'h1E, 8'h0E};
    st_m  = '{16'h0540, 16'h0600, 16'h0630};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_regs();
    axi_rd(16'h0000, {`EESS_RESP_SLVERR, 32'h0});
    axi_rd(ba(`EESS_IDX_L1_CNT) | 16'h0001, {`EESS_RESP_SLVERR, 32'h0});
    $display("test reset_defaults done");

    // default sequence, a second start mid-run must be ignored
    base = 16'($urandom);
    expect_run(base);
    seq_ptr_base <= base;
    seq_start    <= 1'b1;
    @(posedge aclk);
    seq_start    <= 1'b0;
    repeat (20) @(posedge aclk);
    seq_ptr_base <= ~base;
    seq_start    <= 1'b1;
    @(posedge aclk);
    seq_start    <= 1'b0;
    wait_done();
    $display("test default_run done");

    // reprogrammed sequence, single-byte entry and masked write
    cnt_m = '{8'h00, 8'($urandom % 9), 8'($urandom % 9)};
    for (int k = 0; k < 3; k++) begin
      st_m[k] = 16'($urandom) & 16'h7FFF;
      axi_wr(ba(cidx[k]), {24'h0, cnt_m[k]}, 4'h1, `EESS_RESP_OKAY);
      axi_wr(ba(cidx[k] + 14'h1), {16'h0, st_m[k]}, 4'h3, `EESS_RESP_OKAY);
    end
    axi_wr(ba(cidx[2]), 32'hFF, 4'h0, `EESS_RESP_OKAY);
    axi_wr(16'h0000, 32'h1, 4'hF, `EESS_RESP_SLVERR);
    chk_regs();
    base = 16'($urandom);
    expect_run(base);
    seq_ptr_base <= base;
    axi_wr(ba(`EESS_IDX_CTRL), 32'h1, 4'hF, `EESS_RESP_OKAY);
    wait_done();
    $display("test programmed_run done");

    // second reset brings the default bytes back
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cnt_m = '{8'h33, 8'h1E, 8'h0E};
    st_m  = '{16'h0540, 16'h0600, 16'h0630};
    chk_regs();
    axi_rd(ba(`EESS_IDX_STAT), {2'b00, 32'h0});
    $display("test second_reset done");
    test_done();
  end
endmodule // tb
